// ===== verilog/rxfsb_pkg.sv
package rxfsb_pkg;

  // ----------------------------------------
  // Register addresses
  // ----------------------------------------
  localparam logic [7:0] CH1_QUEUE_ADDR = 8'h30;
  localparam logic [7:0] CH1_LEVEL_ADDR = 8'h31;
  localparam logic [7:0] CH1_COND_ADDR = 8'h32;
  localparam logic [7:0] CH2_QUEUE_ADDR = 8'h40;
  localparam logic [7:0] CH2_LEVEL_ADDR = 8'h41;
  localparam logic [7:0] CH2_COND_ADDR = 8'h42;
  localparam logic [7:0] TONE_QUEUE_ADDR = 8'h50;
  localparam logic [7:0] TONE_LEVEL_ADDR = 8'h51;
  localparam logic [7:0] TONE_COND_ADDR = 8'h52;

  // ----------------------------------------
  // Sizes, reset values, field positions
  // ----------------------------------------
  localparam int QUEUE_DEPTH = 32;
  localparam int PTR_W = 5;
  localparam int CNT_W = 6;
  localparam logic [7:0] LEVEL_RESET = 8'h1f;
  localparam logic [15:0] COND_RESET = 16'h0000;
  localparam int OVF_BIT = 15;
  localparam int UDF_BIT = 14;
  localparam int FILL_LSB = 8;
  localparam int TRIG_BIT = 7;
  localparam int LEVEL_W = 5;

  // Channel mode select (two bits per main channel)
  typedef enum logic [1:0] {
    RXFSB_AIS_WIDE = 2'b00,
    RXFSB_AIS_NARROW = 2'b01,
    RXFSB_DSC = 2'b10,
    RXFSB_RESV = 2'b11
  } rxfsb_mode_t;

  // Byte offered by one receive source
  typedef struct packed {
    logic valid;
    logic [7:0] data;
  } rxfsb_byte_t;

  // Host register access request
  typedef struct packed {
    logic rd;
    logic wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } rxfsb_req_t;

endpackage

// ===== verilog/rxfsb_bank.sv
`timescale 1ns/1ps
`default_nettype none

module rxfsb_bank
  import rxfsb_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic clkEn,
  input wire rxfsb_req_t hostReq,
  output logic [15:0] hostRdData,
  input wire rxfsb_byte_t ch1Byte,
  input wire rxfsb_byte_t ch2Byte,
  input wire rxfsb_byte_t extToneByte,
  input wire rxfsb_mode_t ch1Mode,
  input wire rxfsb_mode_t ch2Mode,
  input wire logic [2:0] ch1AisState,
  input wire logic [2:0] ch2AisState,
  output logic [2:0] triggerIrq,
  output logic [2:0] errorIrq
);

  // ----------------------------------------
  // Source steering
  // ----------------------------------------
  rxfsb_byte_t pushIn [3];

  // A channel in DSC mode feeds the tone queue instead of its own
  always_comb begin
    pushIn[0] = ch1Byte;
    pushIn[1] = ch2Byte;
    pushIn[0].valid = ch1Byte.valid && (ch1Mode != RXFSB_DSC);
    pushIn[1].valid = ch2Byte.valid && (ch2Mode != RXFSB_DSC);
    // Channel one wins, then channel two, then the external demodulator
    if (ch1Byte.valid && ch1Mode == RXFSB_DSC) begin
      pushIn[2] = ch1Byte;
    end else if (ch2Byte.valid && ch2Mode == RXFSB_DSC) begin
      pushIn[2] = ch2Byte;
    end else begin
      pushIn[2] = extToneByte;
    end
  end

  // ----------------------------------------
  // Address decode
  // ----------------------------------------
  logic [7:0] queueAddr [3];
  logic [7:0] levelAddr [3];
  logic [7:0] condAddr [3];

  // Fixed register addresses, indexed by queue number
  assign queueAddr[0] = CH1_QUEUE_ADDR;
  assign queueAddr[1] = CH2_QUEUE_ADDR;
  assign queueAddr[2] = TONE_QUEUE_ADDR;
  assign levelAddr[0] = CH1_LEVEL_ADDR;
  assign levelAddr[1] = CH2_LEVEL_ADDR;
  assign levelAddr[2] = TONE_LEVEL_ADDR;
  assign condAddr[0] = CH1_COND_ADDR;
  assign condAddr[1] = CH2_COND_ADDR;
  assign condAddr[2] = TONE_COND_ADDR;

  // ----------------------------------------
  // Per-queue state
  // ----------------------------------------
  // Storage is not reset; the pointers and the fill count say which words are live
  logic [7:0] mem [3][QUEUE_DEPTH];
  logic [PTR_W-1:0] rdPtr_reg [3];
  logic [PTR_W-1:0] wrPtr_reg [3];
  logic [CNT_W-1:0] count_reg [3];
  logic [7:0] level_reg [3];
  logic ovf_reg [3];
  logic udf_reg [3];

  // Assembled status words and head bytes, read by the output mux
  logic [15:0] cond [3];
  logic [7:0] head [3];

  // One-cycle strobes decoded from the host request, the source bytes and the fill count
  logic popReq [3];
  logic condRd [3];
  logic doPush [3];
  logic doPop [3];
  logic isFull [3];
  logic isEmpty [3];

  // ----------------------------------------
  // Per-queue logic
  // ----------------------------------------
  for (genvar q = 0; q < 3; q++) begin : gQueue
    logic [2:0] stateField;
    assign stateField = (q == 2) ? 3'h0 : ((q == 0) ? ch1AisState : ch2AisState);

    assign isFull[q] = (count_reg[q] == CNT_W'(QUEUE_DEPTH));
    assign isEmpty[q] = (count_reg[q] == '0);
    assign popReq[q] = hostReq.rd && (hostReq.addr == queueAddr[q]);
    assign condRd[q] = hostReq.rd && (hostReq.addr == condAddr[q]);
    assign doPush[q] = pushIn[q].valid && !isFull[q];
    assign doPop[q] = popReq[q] && !isEmpty[q];
    assign head[q] = mem[q][rdPtr_reg[q]];

    // Storage array; no reset needed, pointers define contents
    always_ff @(posedge ref_clk) begin
      if (clkEn && doPush[q]) begin
        mem[q][wrPtr_reg[q]] <= pushIn[q].data;
      end
    end

    // Pointers and fill count
    always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
        rdPtr_reg[q] <= '0;
        wrPtr_reg[q] <= '0;
        count_reg[q] <= '0;
      end else if (clkEn) begin
        if (doPush[q]) begin
          wrPtr_reg[q] <= wrPtr_reg[q] + PTR_W'(1);
        end
        if (doPop[q]) begin
          rdPtr_reg[q] <= rdPtr_reg[q] + PTR_W'(1);
        end
        if (doPush[q] && !doPop[q]) begin
          count_reg[q] <= count_reg[q] + CNT_W'(1);
        end else if (doPop[q] && !doPush[q]) begin
          count_reg[q] <= count_reg[q] - CNT_W'(1);
        end
      end
    end

    // ----------------------------------------
    // Trigger level
    // ----------------------------------------
    // Write-only trigger level; upper bits stored but ignored
    always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
        level_reg[q] <= LEVEL_RESET;
      end else if (clkEn && hostReq.wr && hostReq.addr == levelAddr[q]) begin
        level_reg[q] <= hostReq.wdata;
      end
    end

    // ----------------------------------------
    // Error flags and status word
    // ----------------------------------------
    // Sticky error flags; a new event beats the read-clear
    always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
        ovf_reg[q] <= 1'b0;
        udf_reg[q] <= 1'b0;
      end else if (clkEn) begin
        if (pushIn[q].valid && isFull[q]) begin
          ovf_reg[q] <= 1'b1;
        end else if (condRd[q]) begin
          ovf_reg[q] <= 1'b0;
        end
        if (popReq[q] && isEmpty[q]) begin
          udf_reg[q] <= 1'b1;
        end else if (condRd[q]) begin
          udf_reg[q] <= 1'b0;
        end
      end
    end

    // Status word assembly; bits 6-3 always zero
    always_comb begin
      cond[q] = COND_RESET;
      cond[q][OVF_BIT] = ovf_reg[q];
      cond[q][UDF_BIT] = udf_reg[q];
      cond[q][FILL_LSB +: CNT_W] = count_reg[q];
      cond[q][TRIG_BIT] = count_reg[q] > {1'b0, level_reg[q][LEVEL_W-1:0]};
      cond[q][2:0] = stateField;
    end

    // Interrupt sources are plain levels; any edge detection is the host's
    assign triggerIrq[q] = cond[q][TRIG_BIT];
    assign errorIrq[q] = ovf_reg[q] | udf_reg[q];
  end

  // ----------------------------------------
  // Read data
  // ----------------------------------------
  logic [15:0] rdMux;

  // Empty queue reads return zero
  always_comb begin
    rdMux = 16'h0000;
    // At most one address matches, so the order of the tests is free
    for (int i = 0; i < 3; i++) begin
      if (popReq[i] && !isEmpty[i]) begin
        rdMux = {8'h00, head[i]};
      end
      if (condRd[i]) begin
        rdMux = cond[i];
      end
    end
  end

  // Registered so data output is glitch free; one cycle latency
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      hostRdData <= 16'h0000;
    end else if (clkEn && hostReq.rd) begin
      hostRdData <= rdMux;
    end
  end

endmodule

`default_nettype wire

// ===== tb/rxfsb_bank_chk.sv
`timescale 1ns/1ps
`default_nettype none
module rxfsb_bank_chk
  import rxfsb_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic clkEn,
  input wire rxfsb_req_t hostReq,
  input wire logic [15:0] hostRdData,
  input wire rxfsb_byte_t ch1Byte,
  input wire logic [2:0] triggerIrq,
  input wire logic [2:0] errorIrq
);
  logic rdOk;
  logic cond1;
  logic [4:0] lvl1Reg;
  // Mirror of the write-only level, since it cannot be read back
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      lvl1Reg <= LEVEL_RESET[4:0];
    end else if (clkEn && hostReq.wr && hostReq.addr == CH1_LEVEL_ADDR) begin
      lvl1Reg <= hostReq.wdata[4:0];
    end
  end
  // Accepted reads
  assign rdOk = clkEn && hostReq.rd;
  assign cond1 = rdOk && hostReq.addr == CH1_COND_ADDR;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  irq_reset_a: assert property ($rose(rst_b) |-> triggerIrq == 3'h0 && errorIrq == 3'h0)
    else $error("irq active after reset");
  lvl_wo_a: assert property (rdOk && hostReq.addr == CH1_LEVEL_ADDR |=> hostRdData == 16'h0000)
    else $error("level readable");
  zero_gap_a: assert property (rdOk && hostReq.addr[3:0] == 4'h2 |=> hostRdData[6:3] == 4'h0)
    else $error("status gap bits set");
  fill_max_a: assert property (rdOk && hostReq.addr[3:0] == 4'h2 |=> hostRdData[13:8] <= 6'h20)
    else $error("fill above depth");
  trig_bit_a: assert property (cond1 |=> hostRdData[7] == $past(triggerIrq[0]))
    else $error("trigger bit differs from irq");
  trig_level_a: assert property (cond1 |=> hostRdData[7] == (hostRdData[13:8] > {1'b0, $past(lvl1Reg)}))
    else $error("trigger wrong for level");
  err_source_a: assert property (cond1 |=> (hostRdData[15] | hostRdData[14]) == $past(errorIrq[0]))
    else $error("error irq not flag or");
  err_clear_a: assert property (cond1 && !ch1Byte.valid |=> !errorIrq[0])
    else $error("flags not cleared by read");
endmodule
bind rxfsb_bank rxfsb_bank_chk rxfsb_bank_chk_inst (.ref_clk(ref_clk), .rst_b(rst_b),
  .clkEn(clkEn), .hostReq(hostReq), .hostRdData(hostRdData), .ch1Byte(ch1Byte),
  .triggerIrq(triggerIrq), .errorIrq(errorIrq));
`default_nettype wire

// ===== tb/rxfsb_host.sv
`timescale 1ns/1ps
`default_nettype none
module rxfsb_host
  import rxfsb_pkg::*;
(
  input wire logic ref_clk,
  output var rxfsb_req_t hostReq
);
  initial hostReq = '0;
  // One-cycle access launched just after an edge; reserved level bits kept zero
  task automatic acc(input logic r, input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk) #1;
    hostReq = '{rd: r, wr: !r, addr: a, wdata: {3'h0, d[4:0]}};
    @(posedge ref_clk) #1;
    hostReq.rd = 1'b0;
    hostReq.wr = 1'b0;
  endtask
endmodule
`default_nettype wire

// ===== tb/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
  import rxfsb_pkg::*;
  logic ref_clk = 1'b0;
  logic rst_b = 1'b0;
  logic clkEn = 1'b1;
  rxfsb_req_t hostReq;
  logic [15:0] hostRdData;
  rxfsb_byte_t src [3];
  rxfsb_mode_t md [2];
  logic [2:0] ais [3];
  logic [2:0] triggerIrq, errorIrq, ovf, udf;
  logic [7:0] q [3][$];
  logic [4:0] lv [3];
  logic [7:0] d;
  int nMismatch = 0, checksDone = 0, seed = 15, n;
  rxfsb_bank rxfsb_bank_inst (.ref_clk(ref_clk), .rst_b(rst_b), .clkEn(clkEn), .hostReq(hostReq),
    .hostRdData(hostRdData), .ch1Byte(src[0]), .ch2Byte(src[1]), .extToneByte(src[2]),
    .ch1Mode(md[0]), .ch2Mode(md[1]), .ch1AisState(ais[0]), .ch2AisState(ais[1]),
    .triggerIrq(triggerIrq), .errorIrq(errorIrq));
  rxfsb_host rxfsb_host_inst (.ref_clk(ref_clk), .hostReq(hostReq));
  // Clock
  initial forever #4 ref_clk = ~ref_clk;
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    checksDone++;
    if (seen !== exp) begin
      nMismatch++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // One-cycle byte pulse on selected sources, model follows the steering
  task automatic push(input logic [2:0] m, input logic [7:0] b);
    int t;
    @(posedge ref_clk) #1;
    for (int k = 0; k < 3; k++) if (m[k]) begin
      src[k] = '{valid: 1'b1, data: b};
      t = (k < 2 && md[k] == RXFSB_DSC) ? 2 : k;
      if (q[t].size() < QUEUE_DEPTH) q[t].push_back(b);
      else ovf[t] = 1'b1;
    end
    @(posedge ref_clk) #1;
    foreach (src[k]) src[k].valid = 1'b0;
  endtask
  task automatic qrd(input int k);
    logic [7:0] e;
    rxfsb_host_inst.acc(1'b1, 8'h30 + 8'(k * 16), 8'h00);
    e = 8'h00;
    if (q[k].size() > 0) e = q[k].pop_front();
    else udf[k] = 1'b1;
    chk("queue", hostRdData, {8'h00, e});
  endtask
  // Expected status word of queue k, worked out from the model
  function automatic logic [15:0] expCond(input int k);
    return {ovf[k], udf[k], 6'(q[k].size()), 1'(q[k].size() > lv[k]), 4'h0, ais[k]};
  endfunction
  task automatic crd(input int k);
    rxfsb_host_inst.acc(1'b1, 8'h32 + 8'(k * 16), 8'h00);
    chk("status", hostRdData, expCond(k));
    chk("trigger", 16'(triggerIrq[k]), 16'(q[k].size() > lv[k]));
    ovf[k] = 1'b0;
    udf[k] = 1'b0;
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", checksDone, nMismatch);
    if (nMismatch == 0 && checksDone > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // Watchdog, far beyond the several hundred cycles the run needs
  initial begin
    repeat (20000) @(posedge ref_clk);
    nMismatch++;
    complete_run();
  end
  initial begin
    foreach (src[i]) src[i] = '0;
    md = '{RXFSB_AIS_WIDE, RXFSB_AIS_WIDE};
    ais = '{3'h0, 3'h0, 3'h0};
    lv = '{LEVEL_RESET[4:0], LEVEL_RESET[4:0], LEVEL_RESET[4:0]};
    ovf = 3'h0;
    udf = 3'h0;
    repeat (6) @(posedge ref_clk);
    #1 rst_b = 1'b1;
    d = 8'($random(seed));
    md = '{rxfsb_mode_t'({1'b0, d[0]}), rxfsb_mode_t'({1'b0, d[1]})};
    ais[0] = d[4:2];
    ais[1] = d[7:5];
    rxfsb_host_inst.acc(1'b1, 8'h33, 8'h00);
    chk("unmapped", hostRdData, 16'h0000);
    for (int k = 0; k < 3; k++) begin
      crd(k);
      rxfsb_host_inst.acc(1'b1, 8'h31 + 8'(k * 16), 8'h00);
      chk("level", hostRdData, 16'h0000);
      repeat (31) push(3'(1 << k), 8'($random(seed)));
      crd(k);
      repeat (2) push(3'(1 << k), 8'($random(seed)));
      chk("error", 16'(errorIrq[k]), 16'h0001);
      crd(k);
      repeat (33) qrd(k);
      crd(k);
      chk("error", 16'(errorIrq[k]), 16'h0000);
      d = 8'($random(seed));
      lv[k] = d[4:0];
      rxfsb_host_inst.acc(1'b0, 8'h31 + 8'(k * 16), d);
      n = {$random(seed)} % 33;
      repeat (n) push(3'(1 << k), 8'($random(seed)));
      crd(k);
      repeat (n) qrd(k);
    end
    $display("test queues done");
    // Frozen cycles: a byte and a level write offered with clkEn low are lost
    rxfsb_host_inst.acc(1'b0, CH1_LEVEL_ADDR, 8'h05);
    lv[0] = 5'h05;
    clkEn = 1'b0;
    push(3'b001, 8'h77);
    rxfsb_host_inst.acc(1'b0, CH1_LEVEL_ADDR, 8'h00);
    clkEn = 1'b1;
    void'(q[0].pop_back());
    crd(0);
    repeat (3) push(3'b001, 8'($random(seed)));
    crd(0);
    repeat (3) qrd(0);
    $display("test freeze done");
    md = '{RXFSB_DSC, RXFSB_AIS_WIDE};
    push(3'b001, 8'h5a);
    md = '{RXFSB_AIS_NARROW, RXFSB_DSC};
    push(3'b010, 8'ha5);
    md = '{RXFSB_AIS_WIDE, RXFSB_RESV};
    push(3'b111, 8'h3c);
    for (int k = 0; k < 3; k++) crd(k);
    repeat (3) qrd(2);
    qrd(0);
    qrd(1);
    $display("test steering done");
    // Mid-run reset with bytes queued and a level written: all back to reset state
    push(3'b111, 8'hc3);
    rxfsb_host_inst.acc(1'b0, CH1_LEVEL_ADDR, 8'h00);
    rst_b = 1'b0;
    repeat (2) @(posedge ref_clk);
    #1 rst_b = 1'b1;
    foreach (q[i]) q[i].delete();
    lv = '{LEVEL_RESET[4:0], LEVEL_RESET[4:0], LEVEL_RESET[4:0]};
    for (int k = 0; k < 3; k++) crd(k);
    push(3'b001, 8'h01);
    crd(0);
    qrd(0);
    $display("test reset done");
    complete_run();
  end
endmodule
`default_nettype wire
